//--- logic/pab_defines.vh
`ifndef PAB_DEFINES_VH
`define PAB_DEFINES_VH

// register byte offsets
`define PAB_OFS_FIRST_PORT_REG 8'h10
`define PAB_OFS_PORT_B_DATA 8'h14
`define PAB_OFS_DIRB 8'h18
`define PAB_OFS_FLAG 8'h1C
`define PAB_OFS_STAT 8'h20

// field positions
`define PAB_BIT_PULLUP_DIS 7
`define PAB_BIT_CHG_FLAG 7
`define PAB_BIT_OD_LO 2
`define PAB_BIT_OD_HI 3

// reset values
`define PAB_RST_DIRB 8'hFF
`define PAB_RST_LATB 8'h00
`define PAB_RST_OD 2'h3
`define PAB_RST_PULLUP_DIS 1'b0

// bus modes carrying the external system bus
`define PAB_MODE_MICROPROC 2'h0
`define PAB_MODE_EXTENDED 2'h1

`endif

//--- logic/pab_gpio.v
`timescale 1ns/1ns
`include "pab_defines.vh"

module pab_gpio (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire [5:0] pa_in_i,
  output wire [5:0] pa_out_o,
  output wire [5:0] pa_oe_o,
  input wire sync_serial_en_i,
  input wire [1:0] sync_serial_out_i,
  input wire [1:0] sync_serial_oe_i,
  input wire serial_unit_en_i,
  input wire [1:0] serial_unit_out_i,
  input wire [1:0] serial_unit_oe_i,
  output wire ext_irq_pin_o,
  output wire timer0_clk_pin_o,
  output wire [3:0] pa_periph_in_o,
  input wire [7:0] pb_in_i,
  output wire [7:0] pb_out_o,
  output wire [7:0] pb_oe_o,
  output wire [7:0] pb_pullup_o,
  input wire [7:0] pb_periph_en_i,
  input wire [7:0] pb_periph_out_i,
  output wire [7:0] pb_periph_in_o,
  input wire [1:0] bus_mode_i,
  output wire sysbus_sel_o,
  output wire change_irq_flag_o,
  input wire sleep_i,
  output wire wake_o
);

  // bus handshake
  reg ack_q;
  reg ack_d;
  reg [31:0] dat_d;
  reg [7:0] rd_d;
  wire req;
  wire take;
  wire wr;
  wire wr_first_port_reg;
  wire wr_port_b_data;
  wire wr_dirb;
  wire wr_flag;

  // write data fields
  wire [1:0] wdat_od;
  wire wdat_pullup_dis;
  wire [7:0] wdat_byte;
  wire wdat_flag;

  // read data fields
  wire [7:0] rd_first_port_reg;
  wire [7:0] rd_port_b_data;
  wire [7:0] rd_dirb;
  wire [7:0] rd_flag;
  wire [7:0] rd_stat;

  // pin synchronisers
  reg [5:0] pa_s1_q;
  reg [5:0] pa_s2_q;
  reg [7:0] pb_s1_q;
  reg [7:0] pb_s2_q;

  // software visible state
  reg [1:0] od_lat_q;
  reg [1:0] od_lat_d;
  reg pullup_disable_n_q;
  reg pullup_disable_n_d;
  reg [7:0] second_port_reg_q;
  reg [7:0] second_port_reg_d;
  reg [7:0] second_port_dir_q;
  reg [7:0] second_port_dir_d;
  reg change_irq_flag_q;
  reg change_irq_flag_d;

  // change detect
  wire [7:0] pb_input_mask;
  wire [7:0] mismatch;
  wire any_mismatch;

  // pin drive terms
  reg [5:0] pa_out_d;
  reg [5:0] pa_oe_d;
  reg [7:0] pb_out_d;
  reg [7:0] pb_oe_d;
  reg [7:0] pb_pullup_d;
  wire pullup_global_en;

  // offset compare, shared by write strobes and read mux
  function reg_hit;
    input [7:0] adr;
    input [7:0] ofs;
    begin
      reg_hit = (adr == ofs);
    end
  endfunction

  // per-pin choice between peripheral and port logic
  function [7:0] merge8;
    input [7:0] sel;
    input [7:0] a;
    input [7:0] b;
    begin
      merge8 = (sel & a) | (~sel & b);
    end
  endfunction

  function [1:0] merge2;
    input sel;
    input [1:0] a;
    input [1:0] b;
    begin
      if (sel) begin
        merge2 = a;
      end else begin
        merge2 = b;
      end
    end
  endfunction

  // bus modes that hand ports C to E to the external system bus
  function bus_mode_owns_pins;
    input [1:0] mode;
    begin
      case (mode)
        `PAB_MODE_MICROPROC: begin
          bus_mode_owns_pins = 1'b1;
        end
        `PAB_MODE_EXTENDED: begin
          bus_mode_owns_pins = 1'b1;
        end
        default: begin
          bus_mode_owns_pins = 1'b0;
        end
      endcase
    end
  endfunction

  // request decode; a write lands on the take edge only
  assign req = wb_cyc_i & wb_stb_i;
  assign take = req & ~ack_q;
  assign wr = take & wb_we_i & wb_sel_i[0];
  assign wr_first_port_reg = wr & reg_hit(wb_adr_i, `PAB_OFS_FIRST_PORT_REG);
  assign wr_port_b_data = wr & reg_hit(wb_adr_i, `PAB_OFS_PORT_B_DATA);
  assign wr_dirb = wr & reg_hit(wb_adr_i, `PAB_OFS_DIRB);
  assign wr_flag = wr & reg_hit(wb_adr_i, `PAB_OFS_FLAG);
  assign wb_ack_o = ack_q;

  // only the low byte carries register data
  assign wdat_od = wb_dat_i[`PAB_BIT_OD_HI:`PAB_BIT_OD_LO];
  assign wdat_pullup_dis = wb_dat_i[`PAB_BIT_PULLUP_DIS];
  assign wdat_byte = wb_dat_i[7:0];
  assign wdat_flag = wb_dat_i[`PAB_BIT_CHG_FLAG];

  // ack for exactly one cycle per taken request
  always @* begin
    ack_d = take;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  // pin synchronisers, two stages before any use
  always @(posedge clk_i) begin
    if (rst_i) begin
      pa_s1_q <= 6'h00;
      pa_s2_q <= 6'h00;
    end else begin
      pa_s1_q <= pa_in_i;
      pa_s2_q <= pa_s1_q;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      pb_s1_q <= 8'h00;
      pb_s2_q <= 8'h00;
    end else begin
      pb_s1_q <= pb_in_i;
      pb_s2_q <= pb_s1_q;
    end
  end

  // open-drain latch and pull-up control share the port A offset
  always @* begin
    od_lat_d = od_lat_q;
    pullup_disable_n_d = pullup_disable_n_q;
    if (wr_first_port_reg) begin
      od_lat_d = wdat_od;
      pullup_disable_n_d = wdat_pullup_dis;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      od_lat_q <= `PAB_RST_OD;
      pullup_disable_n_q <= `PAB_RST_PULLUP_DIS;
    end else begin
      od_lat_q <= od_lat_d;
      pullup_disable_n_q <= pullup_disable_n_d;
    end
  end

  // port B output latch
  always @* begin
    second_port_reg_d = second_port_reg_q;
    if (wr_port_b_data) begin
      second_port_reg_d = wdat_byte;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      second_port_reg_q <= `PAB_RST_LATB;
    end else begin
      second_port_reg_q <= second_port_reg_d;
    end
  end

  // port B direction, kept while a peripheral overrides a pin
  always @* begin
    second_port_dir_d = second_port_dir_q;
    if (wr_dirb) begin
      second_port_dir_d = wdat_byte;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      second_port_dir_q <= `PAB_RST_DIRB;
    end else begin
      second_port_dir_q <= second_port_dir_d;
    end
  end

  // pins with their direction bit set, even when a peripheral drives them; latch against synchronised pin
  assign pb_input_mask = second_port_dir_q;
  assign mismatch = (pb_s2_q ^ second_port_reg_q) & pb_input_mask;
  assign any_mismatch = |mismatch;

  // set wins over a software clear while a mismatch stands
  always @* begin
    change_irq_flag_d = change_irq_flag_q;
    if (any_mismatch) begin
      change_irq_flag_d = 1'b1;
    end else if (wr_flag) begin
      change_irq_flag_d = wdat_flag;
    end
  end

  // reset value is a choice; software must not trust it
  always @(posedge clk_i) begin
    if (rst_i) begin
      change_irq_flag_q <= 1'b0;
    end else begin
      change_irq_flag_q <= change_irq_flag_d;
    end
  end

  // register images as software reads them
  assign rd_first_port_reg = {pullup_disable_n_q, 1'b0, pa_s2_q};
  assign rd_port_b_data = pb_s2_q;
  assign rd_dirb = second_port_dir_q;
  assign rd_flag = {change_irq_flag_q, 7'h00};
  assign rd_stat = {6'h00, pullup_global_en, sysbus_sel_o};

  // read mux, unmapped offsets read zero
  always @* begin
    rd_d = 8'h00;
    if (reg_hit(wb_adr_i, `PAB_OFS_FIRST_PORT_REG)) begin
      rd_d = rd_first_port_reg;
    end
    if (reg_hit(wb_adr_i, `PAB_OFS_PORT_B_DATA)) begin
      rd_d = rd_port_b_data;
    end
    if (reg_hit(wb_adr_i, `PAB_OFS_DIRB)) begin
      rd_d = rd_dirb;
    end
    if (reg_hit(wb_adr_i, `PAB_OFS_FLAG)) begin
      rd_d = rd_flag;
    end
    if (reg_hit(wb_adr_i, `PAB_OFS_STAT)) begin
      rd_d = rd_stat;
    end
  end

  // read data holds until the next taken request
  always @* begin
    dat_d = wb_dat_o;
    if (take) begin
      dat_d = {24'h000000, rd_d};
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_dat_o <= dat_d;
    end
  end

  // port A: 1:0 input-only, 3:2 open-drain or sync serial, 5:4 serial unit
  always @* begin
    pa_out_d = 6'h00;
    pa_oe_d = 6'h00;
    pa_out_d[3:2] = merge2(sync_serial_en_i, sync_serial_out_i, 2'h0);
    pa_oe_d[3:2] = merge2(sync_serial_en_i, sync_serial_oe_i, ~od_lat_q);
    pa_out_d[5:4] = merge2(serial_unit_en_i, serial_unit_out_i, 2'h0);
    pa_oe_d[5:4] = merge2(serial_unit_en_i, serial_unit_oe_i, 2'h0);
  end

  // port A pins and their peripheral inputs
  assign pa_out_o = pa_out_d;
  assign pa_oe_o = pa_oe_d;
  assign ext_irq_pin_o = pa_s2_q[0];
  assign timer0_clk_pin_o = pa_s2_q[1];
  assign pa_periph_in_o = pa_s2_q[5:2];

  // port B: peripheral takes over when enabled
  assign pullup_global_en = ~pullup_disable_n_q;
  always @* begin
    pb_out_d = merge8(pb_periph_en_i, pb_periph_out_i, second_port_reg_q);
    pb_oe_d = pb_periph_en_i | ~second_port_dir_q;
    pb_pullup_d = {8{pullup_global_en}} & ~pb_oe_d;
  end

  assign pb_out_o = pb_out_d;
  assign pb_oe_o = pb_oe_d;
  assign pb_pullup_o = pb_pullup_d;
  // an output pin loops back through the pad to the peripheral
  assign pb_periph_in_o = pb_s2_q;

  assign sysbus_sel_o = bus_mode_owns_pins(bus_mode_i);

  // change flag output and wake request
  assign change_irq_flag_o = change_irq_flag_q;
  assign wake_o = sleep_i & change_irq_flag_q;

endmodule

//--- verif/pab_gpio_chk.sv
`timescale 1ns/1ns
module pab_gpio_chk (
  input clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o, sync_serial_en_i, serial_unit_en_i,
  input sysbus_sel_o, change_irq_flag_o, sleep_i, wake_o,
  input [1:0] bus_mode_i,
  input [5:0] pa_out_o, pa_oe_o,
  input [7:0] pb_oe_o, pb_pullup_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack");
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack");
  chk_pull_off: assert property ((pb_pullup_o & pb_oe_o) == 8'h00) else $error("pu");
  chk_od_low: assert property (!sync_serial_en_i |-> (pa_out_o[3:2] & pa_oe_o[3:2]) == 2'h0)
    else $error("od");
  chk_in_only: assert property (pa_oe_o[1:0] == 2'h0) else $error("in");
  chk_ser_own: assert property (!serial_unit_en_i |-> pa_oe_o[5:4] == 2'h0) else $error("se");
  chk_bus_mode: assert property (sysbus_sel_o == (bus_mode_i < 2'h2)) else $error("bm");
  chk_wake_flag: assert property (wake_o == (sleep_i && change_irq_flag_o))
    else $error("wk");
endmodule
bind pab_gpio pab_gpio_chk i_pab_gpio_chk (.*);

//--- verif/pab_board.sv
`timescale 1ns/1ns
module pab_board (
  input [5:0] pa_out_o, pa_oe_o,
  input [7:0] pb_out_o, pb_oe_o, pb_pullup_o, key_i,
  output [5:0] pa_in_i,
  output [7:0] pb_in_i
);
  // driven pins read back, others show the board level
  assign pa_in_i = pa_oe_o & pa_out_o | ~pa_oe_o & 6'h2D;
  // pressed key pulls low; an unpulled open pin wanders
  assign pb_in_i = pb_oe_o & pb_out_o | ~pb_oe_o & ~key_i & (pb_pullup_o | ~pb_out_o);
endmodule

//--- verif/pab_gpio_tb.sv
`timescale 1ns/1ns
module pab_gpio_tb;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, sleep_i = 0, wb_ack_o;
  logic sync_serial_en_i = 0, serial_unit_en_i = 0, ext_irq_pin_o, timer0_clk_pin_o;
  logic sysbus_sel_o, change_irq_flag_o, wake_o;
  logic [1:0] sync_serial_out_i = 0, sync_serial_oe_i = 0, serial_unit_out_i = 0;
  logic [1:0] serial_unit_oe_i = 0, bus_mode_i = 1;
  logic [3:0] wb_sel_i = 4'hF, pa_periph_in_o;
  logic [5:0] pa_in_i, pa_out_o, pa_oe_o;
  logic [7:0] wb_adr_i = 0, pb_in_i, pb_out_o, pb_oe_o, pb_pullup_o, pb_periph_in_o, key_i = 0;
  logic [7:0] pb_periph_en_i = 0, pb_periph_out_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o;
  int n_mismatch = 0, samples_checked = 0, cyc = 0;
  pab_gpio i_pab_gpio (.*);
  pab_board i_pab_board (.*);
  initial forever #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (++cyc > 3000) begin
    n_mismatch++;
    summarize;
  end
  task summarize;
    $display("%0d checks %0d mismatches", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // idle gap lets pin changes pass the synchronisers first
  task wb(input [7:0] a, input w, input [7:0] d, input [7:0] e);
    repeat (4) @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, 24'h0, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    if (!w) cmp("read data", e, wb_dat_o[7:0]);
  endtask
  task cmp(input string what, input [7:0] e, input [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s exp %h got %h", what, e, g);
    end
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    wb(8'h18, 0, 0, 8'hFF);
    wb(8'h10, 0, 0, 8'h2D);
    wb(8'h3C, 0, 0, 8'h00);
    wb(8'h10, 1, 8'h80, 0);
    wb(8'h10, 0, 0, 8'hA1);
    wb(8'h10, 1, 8'h0C, 0);
    wb(8'h20, 0, 0, 8'h03);
    wb(8'h14, 1, 8'hA5, 0);
    wb(8'h18, 1, 8'h0F, 0);
    wb(8'h14, 0, 0, 8'hAF);
    @(negedge clk_i);
    cmp("pb_oe_o", 8'hF0, pb_oe_o);
    cmp("pb_out_o", 8'hA5, pb_out_o);
    cmp("pb_pullup_o", 8'h0F, pb_pullup_o);
    cmp("pb_periph_in_o", 8'hAF, pb_periph_in_o);
    wb(8'h14, 1, 8'hAF, 0);
    wb(8'h1C, 1, 0, 0);
    wb(8'h1C, 0, 0, 8'h00);
    key_i <= 8'h01;
    wb(8'h1C, 0, 0, 8'h80);
    wb(8'h1C, 1, 0, 0);
    wb(8'h1C, 0, 0, 8'h80);
    @(negedge clk_i);
    cmp("wake_o", 8'h00, wake_o);
    cmp("change_irq_flag_o", 8'h01, change_irq_flag_o);
    @(posedge clk_i);
    sleep_i <= 1;
    key_i <= 8'h81;
    @(negedge clk_i);
    cmp("wake_o", 8'h01, wake_o);
    wb(8'h14, 1, 8'hAE, 0);
    wb(8'h1C, 1, 0, 0);
    wb(8'h1C, 0, 0, 8'h00);
    @(negedge clk_i);
    cmp("wake_o", 8'h00, wake_o);
    @(posedge clk_i);
    rst_i <= 1;
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    wb(8'h18, 0, 0, 8'hFF);
    wb(8'h10, 0, 0, 8'h2D);
    wb(8'h20, 0, 0, 8'h03);
    @(negedge clk_i);
    cmp("pb_oe_o", 8'h00, pb_oe_o);
    cmp("pb_pullup_o", 8'hFF, pb_pullup_o);
    @(posedge clk_i);
    {sync_serial_en_i, sync_serial_oe_i, sync_serial_out_i} <= 5'h1C;
    {serial_unit_en_i, serial_unit_oe_i, serial_unit_out_i} <= 5'h1D;
    wb(8'h10, 0, 0, 8'h11);
    @(negedge clk_i);
    cmp("ext_irq_pin_o", 8'h01, ext_irq_pin_o);
    cmp("timer0_clk_pin_o", 8'h00, timer0_clk_pin_o);
    cmp("pa_periph_in_o", 8'h04, pa_periph_in_o);
    @(posedge clk_i);
    bus_mode_i <= 2'h2;
    wb(8'h20, 0, 0, 8'h02);
    bus_mode_i <= 2'h0;
    wb(8'h20, 0, 0, 8'h03);
    summarize;
  end
endmodule
